/* File: common/sapc_pkg.sv */
// constants for the serial converter port control block
package sapc_pkg;
   localparam int          FRAME_BITS      = 16;
   localparam int          CTRL_BITS       = 8;
   localparam int          RESULT_BITS     = 12;
   localparam int          LEAD_ZEROS      = 4;
   localparam int          CNT_W           = 5;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam int          CH_HI           = 5;
   localparam int          CH_LO           = 3;
   localparam int          REF_BIT         = 2;
   localparam int          ZERO_BIT        = 6;
   localparam int          IGNORED_BIT     = 7;
   localparam int          PM_HI           = 1;
   localparam int          PM_LO           = 0;
   localparam int          SAR_STEPS       = 12;
   localparam int          BUF_DEPTH       = 2;
endpackage : sapc_pkg

/* File: common/sapc_word_if.sv */
// valid/ready word carrier between the port control and its result buffer
interface sapc_word_if #(parameter int W = 12);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : sapc_word_if

/* File: rtl/sapc_buf.sv */
// two-entry result buffer with valid and ready on both sides
module sapc_buf #(
   parameter int W = 12
) (
   input  wire logic clk,
   input  wire logic rst_n,
   sapc_word_if.dst  in_if,
   sapc_word_if.src  out_if
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic [1:0]        cnt;
      logic              rd;
      logic              wr;
   } sapc_buf_st_t;

   sapc_buf_st_t st_ff;
   sapc_buf_st_t nxt_st;
   logic         push;
   logic         pop;

   assign in_if.ready  = (st_ff.cnt != 2'(sapc_pkg::BUF_DEPTH));
   assign out_if.valid = (st_ff.cnt != 2'h0);
   assign out_if.data  = st_ff.mem[st_ff.rd];
   assign push         = in_if.valid && in_if.ready;
   assign pop          = out_if.valid && out_if.ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_if.data;
         nxt_st.wr            = ~st_ff.wr;
      end
      if (pop) begin
         nxt_st.rd = ~st_ff.rd;
      end
      nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   chk_buf_no_over: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.cnt <= 2'(sapc_pkg::BUF_DEPTH)) else $error("buffer count over depth");
endmodule : sapc_buf

/* File: rtl/sapc_top.sv */
// serial port and conversion control of the eight-input sampling converter
// Function
// R01 - a low chip select starts a conversion and bounds one serial transfer.
// R02 - each control bit on the serial input is captured on a rising serial clock edge.
// R03 - each result bit is driven onto the serial output on a falling serial clock edge.
// R04 - the result word is four zeros then the twelve result bits, most significant first.
// R05 - the conversion advances only on serial clock edges supplied by the host.
// R06 - a three-bit channel field of the control word picks one of eight inputs.
// R07 - when a conversion completes the sampling stage returns to tracking.
// R08 - a transfer is sixteen clocks and only the first eight rising edges load control bits, msb first.
// R09 - the channel field is taken in at the end of the sequence and applies to the next conversion.
// R10 - the eight-bit control register is all zeros after reset.
// R11 - bit 2 disables the reference when set, bit 6 must be zero and bit 7 is ignored.
// R12 - the serial output is released while chip select is high.
module sapc_top (
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   input  wire logic        CS_N,
   input  wire logic        SCLK,
   input  wire logic        SDI,
   input  wire logic        CMP_IN,
   input  wire logic        RESULT_READY,
   output logic             SDO,
   output logic             SDO_OE,
   output logic [2:0]       CHANNEL_SEL,
   output logic             REF_DISABLE,
   output logic [1:0]       POWER_MODE,
   output logic             TRACKING,
   output logic [11:0]      SAR_TRIAL,
   output logic             CTRL_BIT6_ERR,
   output logic             RESULT_VALID,
   output logic [11:0]      RESULT_DATA
);
   typedef enum logic [1:0] {SAPC_IDLE, SAPC_XFER, SAPC_DONE} sapc_state_t;

   typedef struct packed {
      sapc_state_t state;
      logic        cs_q;
      logic        sclk_q;
      logic [4:0]  bits;
      logic [7:0]  shift;
      logic [7:0]  ctrl;
      logic [2:0]  chan;
      logic [3:0]  step;
      logic [11:0] sar;
      logic [15:0] out_word;
      logic        sdo;
      logic        sdo_oe;
      logic        track;
      logic        push;
      logic        err6;
   } sapc_st_t;

   sapc_st_t    st_ff;
   sapc_st_t    nxt_st;
   logic        rise;
   logic        fall;
   logic        cs_fall;
   logic        buf_valid;
   logic [11:0] buf_data;

   sapc_word_if #(.W(sapc_pkg::RESULT_BITS)) res_in ();
   sapc_word_if #(.W(sapc_pkg::RESULT_BITS)) res_out ();

   function automatic logic [11:0] trial_bit(input logic [3:0] s);
      trial_bit = 12'h800 >> s;
   endfunction

   assign rise          = SCLK && !st_ff.sclk_q;
   assign fall          = !SCLK && st_ff.sclk_q;
   assign cs_fall       = !CS_N && st_ff.cs_q;
   assign res_in.valid  = st_ff.push;
   assign res_in.data   = st_ff.sar;
   // output stage takes a word when it is empty or being drained, so a stall loses nothing
   assign res_out.ready = !RESULT_VALID || RESULT_READY;

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.cs_q   = CS_N;
      nxt_st.sclk_q = SCLK;
      nxt_st.push   = 1'b0;
      case (st_ff.state)
         SAPC_IDLE: begin
            if (cs_fall) begin                                  // R01
               nxt_st.state    = SAPC_XFER;
               nxt_st.bits     = '0;
               nxt_st.step     = '0;
               nxt_st.sar      = trial_bit(4'h0);
               nxt_st.track    = 1'b0;
               nxt_st.sdo_oe   = 1'b1;
               nxt_st.sdo      = 1'b0;                          // R04
               nxt_st.out_word = {4'h0, st_ff.sar};
            end
         end
         SAPC_XFER: begin
            if (CS_N) begin
               nxt_st.state  = SAPC_IDLE;                       // R01
               nxt_st.sdo_oe = 1'b0;                            // R12
               nxt_st.track  = 1'b1;
            end else begin
               if (rise) begin                                  // R05
                  nxt_st.bits = st_ff.bits + 5'h01;
                  if (st_ff.bits < 5'(sapc_pkg::CTRL_BITS)) begin    // R08
                     nxt_st.shift = {st_ff.shift[6:0], SDI};    // R02
                  end
                  if (st_ff.bits == 5'(sapc_pkg::CTRL_BITS - 1)) begin
                     nxt_st.ctrl = {st_ff.shift[6:0], SDI};     // R08
                     nxt_st.err6 = st_ff.shift[sapc_pkg::ZERO_BIT - 1]; // R11
                  end
                  if (st_ff.step < 4'(sapc_pkg::SAR_STEPS)) begin
                     nxt_st.sar  = (CMP_IN ? st_ff.sar : st_ff.sar & ~trial_bit(st_ff.step))
                                 | ((st_ff.step < 4'(sapc_pkg::SAR_STEPS - 1)) ?
                                    trial_bit(st_ff.step + 4'h1) : 12'h000);
                     nxt_st.step = st_ff.step + 4'h1;
                  end
                  if (st_ff.bits == 5'(sapc_pkg::FRAME_BITS - 1)) begin
                     nxt_st.state = SAPC_DONE;
                  end
               end
               if (fall) begin                                  // R03
                  nxt_st.out_word = {st_ff.out_word[14:0], 1'b0};
                  nxt_st.sdo      = st_ff.out_word[14];         // R04
               end
            end
         end
         SAPC_DONE: begin
            nxt_st.track = 1'b1;                                // R07
            nxt_st.chan  = st_ff.ctrl[sapc_pkg::CH_HI:sapc_pkg::CH_LO]; // R09
            nxt_st.push  = res_in.ready;
            if (CS_N) begin
               nxt_st.sdo_oe = 1'b0;                            // R12
            end
            if (fall) begin
               nxt_st.sdo = 1'b0;
            end
            if (CS_N && res_in.ready) begin
               nxt_st.state = SAPC_IDLE;
            end else if (!CS_N && res_in.ready) begin
               nxt_st.state = SAPC_IDLE;
            end
         end
         default: begin
            nxt_st.state = SAPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_ff       <= '0;
         st_ff.state <= SAPC_IDLE;
         st_ff.cs_q  <= 1'b1;
         st_ff.track <= 1'b1;
         st_ff.ctrl  <= sapc_pkg::CTRL_RESET;                   // R10
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         SDO           <= 1'b0;
         SDO_OE        <= 1'b0;
         CHANNEL_SEL   <= 3'h0;
         REF_DISABLE   <= 1'b0;
         POWER_MODE    <= 2'h0;
         TRACKING      <= 1'b1;
         SAR_TRIAL     <= 12'h000;
         CTRL_BIT6_ERR <= 1'b0;
         RESULT_VALID  <= 1'b0;
         RESULT_DATA   <= 12'h000;
      end else begin
         SDO           <= st_ff.sdo;
         SDO_OE        <= st_ff.sdo_oe && !CS_N;                // R12
         CHANNEL_SEL   <= st_ff.chan;                           // R06
         REF_DISABLE   <= st_ff.ctrl[sapc_pkg::REF_BIT];        // R11
         POWER_MODE    <= st_ff.ctrl[sapc_pkg::PM_HI:sapc_pkg::PM_LO];
         TRACKING      <= st_ff.track;
         SAR_TRIAL     <= st_ff.sar;
         CTRL_BIT6_ERR <= st_ff.err6;
         RESULT_VALID  <= (buf_valid && res_out.ready) || (RESULT_VALID && !RESULT_READY);
         RESULT_DATA   <= (buf_valid && res_out.ready) ? buf_data : RESULT_DATA;
      end
   end

   assign buf_valid = res_out.valid;
   assign buf_data  = res_out.data;

   sapc_buf #(.W(sapc_pkg::RESULT_BITS)) u_buf (
      .clk    (CORE_CLK),
      .rst_n  (RESETN),
      .in_if  (res_in),
      .out_if (res_out)
   );

   chk_sdo_release: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R12
      CS_N |=> !SDO_OE) else $error("serial output driven with select high");
   chk_frame_start: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R01
      (st_ff.state == SAPC_IDLE && cs_fall) |=> st_ff.state == SAPC_XFER && st_ff.bits == 5'h00)
      else $error("frame did not start on select fall");
   chk_ctrl_load: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R08
      (st_ff.state == SAPC_XFER && !CS_N && rise && st_ff.bits == 5'h07) |=> st_ff.ctrl[0] == $past(SDI))
      else $error("control byte lsb not loaded on eighth edge");
   chk_ctrl_hold: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R08
      (st_ff.bits > 5'h07 && st_ff.state == SAPC_XFER) |=> $stable(st_ff.ctrl) || st_ff.bits == 5'h00)
      else $error("control changed after eighth edge");
   chk_sdo_fall: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R03
      (st_ff.state == SAPC_XFER && !CS_N && !fall) |=> $stable(st_ff.sdo))
      else $error("serial output changed off a falling edge");
   chk_lead_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R04
      (st_ff.state == SAPC_XFER && st_ff.bits < 5'h04) |-> !st_ff.sdo)
      else $error("leading zero missing");
   chk_sar_edge: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R05
      (st_ff.state == SAPC_XFER && !rise) |=> $stable(st_ff.step))
      else $error("conversion advanced without serial clock");
   chk_track_done: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R07
      st_ff.state == SAPC_DONE |=> st_ff.track && st_ff.chan == $past(st_ff.ctrl[5:3]))
      else $error("no return to tracking or channel not taken");
   chk_chan_late: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R09
      st_ff.state == SAPC_XFER |=> $stable(st_ff.chan))
      else $error("channel changed mid conversion");
   chk_ref_bit: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R11
      1'b1 |=> REF_DISABLE == $past(st_ff.ctrl[2]))
      else $error("reference control does not follow bit 2");
   chk_chan_out: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R06
      1'b1 |=> CHANNEL_SEL == $past(st_ff.chan))
      else $error("channel select does not follow stored field");
   chk_ctrl_reset: assert property (@(posedge CORE_CLK) // R10
      $rose(RESETN) |-> st_ff.ctrl == sapc_pkg::CTRL_RESET) else $error("control not zero after reset");
   chk_result_hold: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (RESULT_VALID && !RESULT_READY) |=> RESULT_VALID && $stable(RESULT_DATA))
      else $error("held result dropped or changed during stall");
endmodule : sapc_top

/* File: dv/sapc_host_model.sv */
// host serial port model: frames transfers, writes control bits, reads result bits
module sapc_host_model (
   input  wire logic       clk,
   output logic            cs_n,
   output logic            sclk,
   output logic            sdi,
   input  wire logic       sdo,
   input  wire logic [2:0] ch_sel,
   input  wire logic       trk,
   input  wire logic       oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] mid_ch;
   logic       mid_trk;
   logic       mid_oe;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
   end
   // one frame of nrise clocks; bits after the eighth are the inverted control word
   task automatic frame(input logic [7:0] ctrl, input int nrise, output logic [15:0] rx);
      logic [15:0] tx;
      tx = {ctrl, ~ctrl};
      rx = 16'h0000;
      @(negedge clk);
      cs_n <= 1'b0;
      sdi  <= tx[15];
      repeat (4) @(negedge clk);
      for (int i = 0; i < nrise; i++) begin
         rx = {rx[14:0], sdo};
         sclk <= 1'b1;
         repeat (4) @(negedge clk);
         if (i == 11) begin
            mid_ch  = ch_sel;
            mid_trk = trk;
            mid_oe  = oe;
         end
         sclk <= 1'b0;
         sdi  <= (i < 15) ? tx[14-i] : ~tx[0];
         repeat (4) @(negedge clk);
      end
      cs_n <= 1'b1;
      sdi  <= ~sdi;
      repeat (4) @(negedge clk);
   endtask
endmodule // sapc_host_model

/* File: dv/sapc_top_tb_top.sv */
// self-checking bench for the serial converter port control block
module sapc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] ctrl;
      logic       cmp;
      logic [2:0] ch;
      logic       rf;
      logic [1:0] pm;
   } sapc_row_t;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        cmp_in = 1'b0;
   logic        result_ready = 1'b1;
   logic        cs_n, sclk, sdi, sdo, sdo_oe, ref_dis, trk, bit6_err, res_valid;
   logic [2:0]  ch_sel;
   logic [1:0]  pm;
   logic [11:0] sar, res_data;
   int          err_total = 0;
   int          checks = 0;
   sapc_row_t   rows [5];

   sapc_top dut (.CORE_CLK(core_clk), .RESETN(resetn), .CS_N(cs_n), .SCLK(sclk), .SDI(sdi),
      .CMP_IN(cmp_in), .RESULT_READY(result_ready), .SDO(sdo), .SDO_OE(sdo_oe),
      .CHANNEL_SEL(ch_sel), .REF_DISABLE(ref_dis), .POWER_MODE(pm), .TRACKING(trk),
      .SAR_TRIAL(sar), .CTRL_BIT6_ERR(bit6_err), .RESULT_VALID(res_valid), .RESULT_DATA(res_data));
   // a released output reads back inverted, so a late enable corrupts the received word
   sapc_host_model host (.clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_oe ? sdo : ~sdo),
      .ch_sel(ch_sel), .trk(trk), .oe(sdo_oe));

   always #12.5 core_clk = ~core_clk;

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic reset_check();
      chk_word({10'h000, ch_sel, ref_dis, pm}, 16'h0000);
      chk_bit(trk, 1'b1);
      chk_bit(sdo_oe, 1'b0);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      final_report();
   end

   initial begin
      logic [15:0] rx;
      logic [11:0] code;
      logic [11:0] prev;
      logic [2:0]  prev_ch;
      logic [11:0] got [4];
      int          n;
      rows[0] = '{8'h00, 1'b1, 3'h0, 1'b0, 2'h0};
      rows[1] = '{8'h2D, 1'b0, 3'h5, 1'b1, 2'h1};
      rows[2] = '{8'h9A, 1'b1, 3'h3, 1'b0, 2'h2};
      rows[3] = '{8'h3F, 1'b0, 3'h7, 1'b1, 2'h3};
      rows[4] = '{8'h83, 1'b1, 3'h0, 1'b0, 2'h3};
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      repeat (3) @(negedge core_clk);
      reset_check();
      prev = 12'h000;
      prev_ch = 3'h0;
      for (int r = 0; r < 5; r++) begin
         cmp_in = rows[r].cmp;
         code = rows[r].cmp ? 12'hFFF : 12'h000;
         host.frame(rows[r].ctrl, 16, rx);
         chk_word(rx, {4'h0, prev});
         chk_word({13'h0000, host.mid_ch}, {13'h0000, prev_ch});
         chk_bit(host.mid_trk, 1'b0);
         chk_bit(host.mid_oe, 1'b1);
         chk_word({4'h0, sar}, {4'h0, code});
         chk_word({13'h0000, ch_sel}, {13'h0000, rows[r].ch});
         chk_bit(ref_dis, rows[r].rf);
         chk_word({14'h0000, pm}, {14'h0000, rows[r].pm});
         chk_bit(trk, 1'b1);
         chk_bit(sdo_oe, 1'b0);
         chk_bit(bit6_err, 1'b0);
         prev = code;
         prev_ch = rows[r].ch;
      end
      // aborted frame leaves the control fields alone
      host.frame(8'h38, 5, rx);
      chk_word({11'h000, ch_sel, pm}, {11'h000, 3'h0, 2'h3});
      chk_bit(sdo_oe, 1'b0);
      // receiver stalls while two results are produced
      result_ready = 1'b0;
      cmp_in = 1'b1;
      host.frame(8'h40, 16, rx);
      chk_bit(bit6_err, 1'b1);
      cmp_in = 1'b0;
      host.frame(8'h3E, 16, rx);
      chk_word(rx, 16'h0FFF);
      chk_bit(res_valid, 1'b1);
      chk_bit(bit6_err, 1'b0);
      chk_word({13'h0000, ch_sel}, {13'h0000, 3'h7});
      result_ready = 1'b1;
      n = 0;
      // sampled off the clock edge: each word shows valid for one cycle while ready stays high
      for (int k = 0; k < 20; k++) begin
         if (res_valid === 1'b1 && n < 4) begin
            got[n] = res_data;
            n++;
         end
         @(negedge core_clk);
      end
      @(negedge core_clk);
      chk_word(16'(n), 16'h0002);
      chk_word({4'h0, got[0]}, 16'h0FFF);
      chk_word({4'h0, got[1]}, 16'h0000);
      resetn = 1'b0;
      repeat (3) @(negedge core_clk);
      resetn = 1'b1;
      repeat (3) @(negedge core_clk);
      reset_check();
      final_report();
   end
endmodule // sapc_top_tb_top
